//--- rtl/board_info_pkg.sv
// offsets, load slots and field masks of the board information bank
package board_info_pkg;
  // register addresses as seen on the register port
  localparam logic [11:0] hw_revision_off = 12'h7da;
  localparam logic [11:0] exp_revision_off = 12'h7db;
  localparam logic [11:0] prod_date_off = 12'h7e4;
  localparam logic [11:0] unique_number_off = 12'h7ee;
  localparam logic [11:0] max_rate_off = 12'h834;
  localparam logic [11:0] mem_bytes_off = 12'h83e;
  localparam logic [11:0] option_bits_off = 12'h848;
  localparam logic [11:0] load_status_off = 12'h850;
  // slot numbers used by the nonvolatile loader
  localparam logic [2:0] hw_revision_slot = 3'h0;
  localparam logic [2:0] exp_revision_slot = 3'h1;
  localparam logic [2:0] prod_date_slot = 3'h2;
  localparam logic [2:0] unique_number_slot = 3'h3;
  localparam logic [2:0] max_rate_slot = 3'h4;
  localparam logic [2:0] mem_bytes_slot = 3'h5;
  localparam logic [2:0] option_bits_slot = 3'h6;
  localparam int info_words = 7;
  // field masks
  localparam logic [31:0] hw_revision_mask = 32'h0000ffff;
  localparam logic [31:0] prod_date_mask = 32'hffff00ff;
  localparam logic [31:0] multi_record_option_flag = 32'h00000001;
  localparam logic [31:0] digital_io_option_flag = 32'h00000002;
  localparam logic [31:0] gated_sampling_option_flag = 32'h00000020;
  localparam logic [31:0] synchronization_option_flag = 32'h00000200;
  localparam logic [31:0] timestamp_option_flag = 32'h00000400;
  localparam logic [31:0] hub_module_flag = 32'h00000800;
  localparam logic [31:0] extra_io_option_flag = 32'h00002000;
  localparam logic [31:0] amplifier_calibration_flag = 32'h00004000;
  localparam logic [31:0] option_valid_mask = 32'h00006e23;
  // values after reset
  localparam logic [31:0] info_reset = 32'h00000000;
  localparam logic [31:0] read_idle = 32'h00000000;
endpackage

//--- rtl/board_information_registers.sv
// read-only board information bank filled from the nonvolatile store
// How it works
// - revision word: base board revision in 15:8, module revision in 7:0
// - expansion revision word returns the fitted module's revision as integer
// - date word is 32 bits: year in 31:16, month in 7:0
// - date bits 15:8 carry nothing; they read zero, readers mask them
// - unique number word returns this board's own serial value
// - top sample rate in hertz, 32-bit, ignoring channel limits
// - installed sample memory size in bytes, 32-bit
// - option bits: 1 multi record, 2 digital io, 32 gated sampling
// - bit 512 set when any synchronization option is installed
// - bit 1024 timestamp option, bit 8192 extra io option
// - bit 2048 hub module, always together with the synchronization bit
// - bit 16384 amplifier calibration, only on waveform generator boards
// - words filled from nonvolatile store until the loader signals done, then read-only
`timescale 1ns/100ps
module board_information_registers #(
  parameter bit gen_board = 1'b0
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [11:0] addr_i,
  input wire logic [31:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rd_data_o,
  input wire logic nv_valid_i,
  input wire logic [2:0] nv_slot_i,
  input wire logic [31:0] nv_data_i,
  input wire logic nv_done_i,
  input wire logic expansion_present_i,
  output logic info_loaded_o
);
  import board_info_pkg::*;

  logic [31:0] info_reg [info_words];
  logic loaded_reg;
  logic exp_meta_reg;
  logic exp_sync_reg;
  logic [31:0] rd_data_reg;
  logic [31:0] rd_data_next;

  // address decode, shared by read path and checks
  function automatic logic [3:0] slot_of(input logic [11:0] a);
    logic [3:0] s;
    s = 4'h8;
    unique case (a)
      hw_revision_off: s = {1'b0, hw_revision_slot};
      exp_revision_off: s = {1'b0, exp_revision_slot};
      prod_date_off: s = {1'b0, prod_date_slot};
      unique_number_off: s = {1'b0, unique_number_slot};
      max_rate_off: s = {1'b0, max_rate_slot};
      mem_bytes_off: s = {1'b0, mem_bytes_slot};
      option_bits_off: s = {1'b0, option_bits_slot};
      default: s = 4'h8;
    endcase
    return s;
  endfunction

  // sanitise a loaded word so undefined fields can never leak out
  function automatic logic [31:0] clean(input logic [2:0] slot, input logic [31:0] d);
    logic [31:0] o;
    o = d;
    if (slot == hw_revision_slot) begin
      o = d & hw_revision_mask;
    end else if (slot == prod_date_slot) begin
      o = d & prod_date_mask;
    end else if (slot == option_bits_slot) begin
      o = d & option_valid_mask;
      if ((d & hub_module_flag) != 32'h0) begin
        o = o | synchronization_option_flag;
      end
      if (!gen_board) begin
        o = o & ~amplifier_calibration_flag;
      end
    end
    return o;
  endfunction

  wire [3:0] rd_slot = slot_of(addr_i);
  wire rd_hit = !rd_slot[3];
  wire rd_status = addr_i == load_status_off;
  wire load_ok = nv_valid_i && !loaded_reg && nv_slot_i < 3'(info_words);
  wire [31:0] nv_clean = clean(nv_slot_i, nv_data_i);
  // an absent expansion module reads as revision zero
  wire exp_gate = rd_slot[2:0] != exp_revision_slot || exp_sync_reg;
  wire [31:0] rd_word = rd_hit ? (exp_gate ? info_reg[rd_slot[2:0]] : read_idle) : read_idle;
  wire [31:0] status_word = {31'h0, loaded_reg};

  always_comb begin
    rd_data_next = read_idle;
    if (rd_i) begin
      rd_data_next = rd_status ? status_word : rd_word;
    end
  end

  // pin from the expansion connector, two flops before use
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      exp_meta_reg <= 1'b0;
      exp_sync_reg <= 1'b0;
    end else begin
      exp_meta_reg <= expansion_present_i;
      exp_sync_reg <= exp_meta_reg;
    end
  end

  // only the loader writes storage; wr_i and wr_data_i are deliberately unused
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < info_words; i++) begin
        info_reg[i] <= info_reset;
      end
    end else if (load_ok) begin
      info_reg[nv_slot_i] <= nv_clean;
    end
  end

  // loaded is sticky until reset, locking the bank
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      loaded_reg <= 1'b0;
    end else if (nv_done_i) begin
      loaded_reg <= 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_reg <= read_idle;
    end else begin
      rd_data_reg <= rd_data_next;
    end
  end

  assign rd_data_o = rd_data_reg;
  assign info_loaded_o = loaded_reg;

  // the loader compares slots in three bits, so seven words at most
  if (info_words > 7) begin : slot_range_g
    $error("info_words does not fit the three-bit loader slot");
  end

  // hub flag means nothing unless the synchronization flag survives the mask
  if ((option_valid_mask & synchronization_option_flag) == 32'h0) begin : sync_mask_g
    $error("option mask drops the synchronization flag");
  end

  rev_upper_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    rd_i && addr_i == hw_revision_off |=> rd_data_o[31:16] == 16'h0)
    else $error("revision word upper half not zero");

  exp_absent_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    rd_i && addr_i == exp_revision_off && !exp_sync_reg |=> rd_data_o == 32'h0)
    else $error("expansion revision shown without module");

  date_gap_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    rd_i && addr_i == prod_date_off |=> rd_data_o[15:8] == 8'h0)
    else $error("date word middle byte not zero");

  mem_word_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    rd_i && addr_i == mem_bytes_off |=> rd_data_o == $past(info_reg[mem_bytes_slot]))
    else $error("memory size word differs from stored value");

  option_mask_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    rd_i && addr_i == option_bits_off |=> (rd_data_o & ~option_valid_mask) == 32'h0)
    else $error("undefined option bit set");

  hub_sync_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    rd_i && addr_i == option_bits_off && nv_valid_i == 1'b0
    |=> !rd_data_o[11] || rd_data_o[9])
    else $error("hub flag without synchronization flag");

  amp_gen_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    rd_i && addr_i == option_bits_off && !gen_board |=> !rd_data_o[14])
    else $error("amplifier flag on non-generator board");

  locked_bank_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    info_loaded_o |=> $stable(info_reg[option_bits_slot]) && $stable(info_reg[unique_number_slot]))
    else $error("information word changed after loading");

  write_keep_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    wr_i && !nv_valid_i
    |=> $stable(info_reg[max_rate_slot]) && $stable(info_reg[hw_revision_slot]))
    else $error("software write altered a word");

  read_pulse_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !rd_i |=> rd_data_o == 32'h0)
    else $error("read data outside the answer cycle");

  // read answers carry the stored word of the addressed slot, the expansion slot only while the module is present
  rev_word_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    rd_i && addr_i == hw_revision_off
    |=> rd_data_o == $past(info_reg[hw_revision_slot]))
    else $error("revision word differs from stored value");

  exp_present_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    rd_i && addr_i == exp_revision_off && exp_sync_reg
    |=> rd_data_o == $past(info_reg[exp_revision_slot]))
    else $error("expansion revision differs from stored value");

  date_word_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    rd_i && addr_i == prod_date_off
    |=> rd_data_o == $past(info_reg[prod_date_slot]))
    else $error("date word differs from stored value");

  serial_word_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    rd_i && addr_i == unique_number_off
    |=> rd_data_o == $past(info_reg[unique_number_slot]))
    else $error("unique number differs from stored value");

  rate_word_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    rd_i && addr_i == max_rate_off
    |=> rd_data_o == $past(info_reg[max_rate_slot]))
    else $error("sample rate word differs from stored value");

  option_word_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    rd_i && addr_i == option_bits_off
    |=> rd_data_o == $past(info_reg[option_bits_slot]))
    else $error("option word differs from stored value");

  status_read_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    rd_i && rd_status
    |=> rd_data_o == {31'h0, $past(info_loaded_o)})
    else $error("load status word wrong");

  unmapped_zero_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    rd_i && rd_slot[3] && !rd_status
    |=> rd_data_o == 32'h0)
    else $error("unmapped address answered with data");

  write_quiet_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    wr_i && !rd_i
    |=> rd_data_o == 32'h0)
    else $error("write produced read data");

  // stored words never hold bits left undefined
  rev_store_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    info_reg[hw_revision_slot][31:16] == 16'h0)
    else $error("stored revision upper half not zero");

  date_store_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    info_reg[prod_date_slot][15:8] == 8'h0)
    else $error("stored date middle byte not zero");

  option_store_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (info_reg[option_bits_slot] & ~option_valid_mask) == 32'h0)
    else $error("stored option word has undefined bits");

  hub_store_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (info_reg[option_bits_slot] & hub_module_flag) == 32'h0
    || (info_reg[option_bits_slot] & synchronization_option_flag) != 32'h0)
    else $error("stored hub flag without synchronization flag");

  amp_store_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    gen_board || (info_reg[option_bits_slot] & amplifier_calibration_flag) == 32'h0)
    else $error("stored amplifier flag on non-generator board");

  // a taken loader word lands in its slot, sanitised
  rev_load_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    load_ok && nv_slot_i == hw_revision_slot
    |=> info_reg[hw_revision_slot] == ($past(nv_data_i) & hw_revision_mask))
    else $error("revision word not stored from loader");

  exp_load_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    load_ok && nv_slot_i == exp_revision_slot
    |=> info_reg[exp_revision_slot] == $past(nv_data_i))
    else $error("expansion revision not stored from loader");

  date_load_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    load_ok && nv_slot_i == prod_date_slot
    |=> info_reg[prod_date_slot] == ($past(nv_data_i) & prod_date_mask))
    else $error("date word not stored from loader");

  serial_load_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    load_ok && nv_slot_i == unique_number_slot
    |=> info_reg[unique_number_slot] == $past(nv_data_i))
    else $error("unique number not stored from loader");

  rate_load_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    load_ok && nv_slot_i == max_rate_slot
    |=> info_reg[max_rate_slot] == $past(nv_data_i))
    else $error("sample rate not stored from loader");

  mem_load_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    load_ok && nv_slot_i == mem_bytes_slot
    |=> info_reg[mem_bytes_slot] == $past(nv_data_i))
    else $error("memory size not stored from loader");

  option_keep_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    load_ok && nv_slot_i == option_bits_slot
    |=> ((info_reg[option_bits_slot] ^ $past(nv_data_i))
    & (multi_record_option_flag | digital_io_option_flag | gated_sampling_option_flag)) == 32'h0)
    else $error("basic option bits not stored from loader");

  sync_set_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    load_ok && nv_slot_i == option_bits_slot
    && (nv_data_i & synchronization_option_flag) != 32'h0
    |=> (info_reg[option_bits_slot] & synchronization_option_flag) != 32'h0)
    else $error("synchronization flag lost on load");

  extra_opts_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    load_ok && nv_slot_i == option_bits_slot
    |=> ((info_reg[option_bits_slot] ^ $past(nv_data_i))
    & (timestamp_option_flag | extra_io_option_flag)) == 32'h0)
    else $error("timestamp or extra io flag not stored from loader");

  amp_keep_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    load_ok && nv_slot_i == option_bits_slot && gen_board
    |=> ((info_reg[option_bits_slot] ^ $past(nv_data_i))
    & amplifier_calibration_flag) == 32'h0)
    else $error("amplifier flag not stored on generator board");

  // once loaded, neither loader nor software moves a word
  locked_rest_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    info_loaded_o
    |=> $stable(info_reg[hw_revision_slot]) && $stable(info_reg[exp_revision_slot])
    && $stable(info_reg[prod_date_slot]) && $stable(info_reg[max_rate_slot])
    && $stable(info_reg[mem_bytes_slot]))
    else $error("locked word changed");

  write_rest_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    wr_i && !nv_valid_i
    |=> $stable(info_reg[exp_revision_slot]) && $stable(info_reg[prod_date_slot])
    && $stable(info_reg[unique_number_slot]) && $stable(info_reg[mem_bytes_slot])
    && $stable(info_reg[option_bits_slot]))
    else $error("software write altered a stored word");

  slot_refused_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    nv_valid_i && nv_slot_i == 3'h7
    |=> $stable(info_reg[hw_revision_slot]) && $stable(info_reg[option_bits_slot]))
    else $error("load to the spare slot changed a word");

  loaded_set_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    nv_done_i |=> info_loaded_o)
    else $error("bank not locked after loader finished");

  loaded_sticky_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    info_loaded_o |=> info_loaded_o)
    else $error("lock dropped without reset");

  loaded_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !info_loaded_o && !nv_done_i |=> !info_loaded_o)
    else $error("lock raised without loader finishing");

  // pin reaches reads two edges after sampling; skip edges right after reset
  exp_sync_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $past(rst_n_i) && $past(rst_n_i, 2)
    |-> exp_sync_reg == $past(expansion_present_i, 2))
    else $error("expansion pin not passed through two stages");
endmodule

//--- verification/tb.sv
// self-checking bench for the board information bank
`timescale 1ns/100ps
module tb;
  import board_info_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [11:0] addr_i = 12'h000;
  logic [31:0] wr_data_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic nv_valid_i = 1'b0;
  logic [2:0] nv_slot_i = 3'h0;
  logic [31:0] nv_data_i = 32'h0;
  logic nv_done_i = 1'b0;
  logic expansion_present_i = 1'b0;
  logic [31:0] rd_data_o;
  logic info_loaded_o;
  logic [31:0] gen_rd_data;
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;
  logic [11:0] offs [7] = '{hw_revision_off, exp_revision_off, prod_date_off,
    unique_number_off, max_rate_off, mem_bytes_off, option_bits_off};
  logic [31:0] vals [7] = '{32'h00001234, 32'h00000005, 32'h07e20005, 32'h00012345,
    32'h0ee6b280, 32'h20000000, 32'h00000a01};
  always #2 mclk_i = ~mclk_i;
  board_information_registers board_information_registers_inst (.mclk_i(mclk_i),
    .rst_n_i(rst_n_i), .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
    .rd_data_o(rd_data_o), .nv_valid_i(nv_valid_i), .nv_slot_i(nv_slot_i),
    .nv_data_i(nv_data_i), .nv_done_i(nv_done_i),
    .expansion_present_i(expansion_present_i), .info_loaded_o(info_loaded_o));
  // second bank built as a waveform generator board, fed the same traffic
  if (1'b1) begin : gen_board_g
    board_information_registers #(.gen_board(1'b1)) board_information_registers_inst (
      .mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
      .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(gen_rd_data), .nv_valid_i(nv_valid_i),
      .nv_slot_i(nv_slot_i), .nv_data_i(nv_data_i), .nv_done_i(nv_done_i),
      .expansion_present_i(expansion_present_i), .info_loaded_o());
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      stop_test();
    end
  end
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    @(posedge mclk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 check(rd_data_o, e);
  endtask
  task automatic rd_val(input logic [11:0] a, output logic [31:0] d);
    @(posedge mclk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 d = rd_data_o;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wr_data_i <= d;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask
  task automatic load(input logic [2:0] s, input logic [31:0] d);
    @(posedge mclk_i);
    nv_valid_i <= 1'b1;
    nv_slot_i <= s;
    nv_data_i <= d;
    @(posedge mclk_i);
    nv_valid_i <= 1'b0;
  endtask
  task automatic test_reset();
    check({31'h0, info_loaded_o}, 32'h0);
    for (int i = 0; i < 7; i++) rd_chk(offs[i], 32'h0);
  endtask
  task automatic test_load();
    load(hw_revision_slot, 32'hdead1234);
    load(exp_revision_slot, 32'h00000005);
    load(prod_date_slot, 32'h07e2ab05);
    load(unique_number_slot, 32'h00012345);
    load(max_rate_slot, 32'h0ee6b280);
    load(mem_bytes_slot, 32'h20000000);
    // overwrite before done; hub without sync and a generator-only bit
    load(option_bits_slot, 32'hffffffff);
    load(option_bits_slot, 32'h0000c801);
    @(posedge mclk_i);
    nv_done_i <= 1'b1;
    @(posedge mclk_i);
    nv_done_i <= 1'b0;
    #1 check({31'h0, info_loaded_o}, 32'h1);
    rd_chk(exp_revision_off, 32'h0);
    @(posedge mclk_i);
    expansion_present_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    rd_chk(hw_revision_off, vals[0]);
    rd_chk(exp_revision_off, vals[1]);
    rd_chk(prod_date_off, vals[2]);
    rd_chk(unique_number_off, vals[3]);
    rd_chk(max_rate_off, vals[4]);
    rd_chk(mem_bytes_off, vals[5]);
    rd_chk(option_bits_off, vals[6]);
  endtask
  task automatic test_lock();
    for (int i = 0; i < 7; i++) wr(offs[i], ~vals[i]);
    for (int i = 0; i < 7; i++) load(i[2:0], 32'h00006e23);
    for (int i = 0; i < 7; i++) rd_chk(offs[i], vals[i]);
    rd_chk(load_status_off, 32'h1);
    rd_chk(12'h7dc, 32'h0);
    @(posedge mclk_i);
    #1 check(rd_data_o, 32'h0);
  endtask
  task automatic test_mask();
    logic [31:0] w;
    rd_val(option_bits_off, w);
    check(gen_rd_data, 32'h00004a01);
    check(w & hub_module_flag, hub_module_flag);
    check(w & synchronization_option_flag, synchronization_option_flag);
    check(w & timestamp_option_flag, 32'h0);
    check(w & amplifier_calibration_flag, 32'h0);
    rd_val(mem_bytes_off, w);
    check(w >> 1, 32'h10000000);
  endtask
  task automatic test_reload();
    @(posedge mclk_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    #1 check({31'h0, info_loaded_o}, 32'h0);
    load(3'h7, 32'hffffffff);
    @(posedge mclk_i);
    nv_valid_i <= 1'b1;
    nv_slot_i <= option_bits_slot;
    nv_data_i <= 32'h00002422;
    nv_done_i <= 1'b1;
    @(posedge mclk_i);
    nv_valid_i <= 1'b0;
    nv_done_i <= 1'b0;
    rd_chk(option_bits_off, 32'h00002422);
    check(gen_rd_data, 32'h00002422);
    rd_chk(hw_revision_off, 32'h0);
    rd_chk(load_status_off, 32'h1);
  endtask
  initial begin
    repeat (4) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    test_reset();
    test_load();
    test_lock();
    test_mask();
    test_reload();
    stop_test();
  end
endmodule
